/* shared/dpr_pkg.sv */
// constants, encodings and types shared by the dual-port block memory
// assumes one system clock; both ports sit in that clock domain
package dpr_pkg;

  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int DPR_ADDR_W = 14;  // widest address, 16K x 1
  localparam int DPR_DATA_W = 36;  // widest word, 512 x 36
  localparam int DPR_BE_W   = 4;   // byte lanes in the widest word
  localparam int DPR_ROW_W  = 9;   // 512 physical rows
  localparam int DPR_ROWS   = 512;
  localparam int DPR_LANE8  = 8;   // lane width, plain byte group
  localparam int DPR_LANE9  = 9;   // lane width, nine-bit group

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [35:0] DPR_DOUT_RST = 36'h0_0000_0000;

  // ****************************************************************
  // word organisations, one code per width
  // ****************************************************************
  localparam logic [3:0] DPR_W1  = 4'h0;
  localparam logic [3:0] DPR_W2  = 4'h1;
  localparam logic [3:0] DPR_W4  = 4'h2;
  localparam logic [3:0] DPR_W8  = 4'h3;
  localparam logic [3:0] DPR_W16 = 4'h4;
  localparam logic [3:0] DPR_W32 = 4'h5;
  localparam logic [3:0] DPR_W9  = 4'h6;
  localparam logic [3:0] DPR_W18 = 4'h7;
  localparam logic [3:0] DPR_W36 = 4'h8;

  // ****************************************************************
  // modes
  // ****************************************************************
  typedef enum logic [1:0] {
    DPR_SINGLE = 2'h0,
    DPR_DUAL   = 2'h1,
    DPR_SEMI   = 2'h2
  } dpr_pmode_t;

  typedef enum logic [1:0] {
    DPR_CLK_INDEP  = 2'h0,
    DPR_CLK_RW     = 2'h1,
    DPR_CLK_SINGLE = 2'h2
  } dpr_cmode_t;

  typedef enum logic [1:0] {
    DPR_WR_NORMAL = 2'h0,
    DPR_WR_THRU   = 2'h1,
    DPR_WR_RBW    = 2'h2
  } dpr_wmode_t;

endpackage

/* logic/dpr_mem.sv */
// physical array of the block memory: 512 rows of 36 bits, two ports
// assumes callers present bit masks; read data are old contents
`timescale 1ns/1ps
module dpr_mem
  import dpr_pkg::*;
(
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic [1:0]           en_i,
  input  wire logic [1:0]           we_i,
  input  wire logic [DPR_ROW_W-1:0] row_a_i,
  input  wire logic [DPR_ROW_W-1:0] row_b_i,
  input  wire logic [35:0]          mask_a_i,
  input  wire logic [35:0]          mask_b_i,
  input  wire logic [35:0]          wdata_a_i,
  input  wire logic [35:0]          wdata_b_i,
  output logic      [35:0]          rdata_a_o,
  output logic      [35:0]          rdata_b_o
);

  logic [35:0] ram [DPR_ROWS];
  logic [35:0] merged_a;
  logic [35:0] base_b;

  // ****************************************************************
  // writes
  // ****************************************************************
  // a same-row collision merges both writes, port b wins on shared bits
  assign merged_a = (ram[row_a_i] & ~mask_a_i) | (wdata_a_i & mask_a_i);
  assign base_b   = (we_i[0] && row_a_i == row_b_i) ? merged_a
                                                     : ram[row_b_i];

  always_ff @(posedge sys_clk_i) begin
    if (we_i[0]) begin
      ram[row_a_i] <= merged_a;
    end
    if (we_i[1]) begin
      ram[row_b_i] <= (base_b & ~mask_b_i) | (wdata_b_i & mask_b_i);
    end
  end

  // ****************************************************************
  // registered reads, read-first
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rdata_a_o <= DPR_DOUT_RST;
      rdata_b_o <= DPR_DOUT_RST;
    end else begin
      if (en_i[0]) begin
        rdata_a_o <= ram[row_a_i];
      end
      if (en_i[1]) begin
        rdata_b_o <= ram[row_b_i];
      end
    end
  end

endmodule

/* logic/dpr_top.sv */
// dual-port block memory with mixed widths, byte enables, output stage
// assumes port clocks arrive as one-cycle enables on sys_clk_i
`timescale 1ns/1ps
module dpr_top
  import dpr_pkg::*;
(
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_n_i,
  input  wire dpr_pmode_t            port_mode_i,
  input  wire dpr_cmode_t            clock_mode_i,
  input  wire logic                  port_a_clock_i,
  input  wire logic                  port_b_clock_i,
  input  wire logic                  port_a_ce_i,
  input  wire logic                  port_b_ce_i,
  input  wire logic                  port_a_write_enable_i,
  input  wire logic                  port_b_write_enable_i,
  input  wire logic [3:0]            port_a_width_i,
  input  wire logic [3:0]            port_b_width_i,
  input  wire dpr_wmode_t            port_a_write_mode_i,
  input  wire dpr_wmode_t            port_b_write_mode_i,
  input  wire logic                  port_a_pipeline_i,
  input  wire logic                  port_b_pipeline_i,
  input  wire logic                  port_a_output_reg_enable_i,
  input  wire logic                  port_b_output_reg_enable_i,
  input  wire logic [DPR_ADDR_W-1:0] port_a_addr_i,
  input  wire logic [DPR_ADDR_W-1:0] port_b_addr_i,
  input  wire logic [DPR_DATA_W-1:0] port_a_data_i,
  input  wire logic [DPR_DATA_W-1:0] port_b_data_i,
  input  wire logic [DPR_BE_W-1:0]   port_a_byte_en_i,
  input  wire logic [DPR_BE_W-1:0]   port_b_byte_en_i,
  output logic      [DPR_DATA_W-1:0] port_a_data_o,
  output logic      [DPR_DATA_W-1:0] port_b_data_o,
  output logic                       cfg_error_o
);

  // ****************************************************************
  // width helpers
  // ****************************************************************
  function automatic logic is_g9(input logic [3:0] code);
    return code >= DPR_W9;
  endfunction

  // address bits that pick the word inside a row
  function automatic int word_shift(input logic [3:0] code);
    return is_g9(code) ? 8 - int'(code) : 5 - int'(code);
  endfunction

  function automatic int word_bits(input logic [3:0] code);
    return is_g9(code) ? (DPR_LANE9 << (int'(code) - 6))
                       : (1 << int'(code));
  endfunction

  function automatic logic [DPR_ROW_W-1:0] row_of(
    input logic [3:0] code, input logic [DPR_ADDR_W-1:0] addr);
    logic [DPR_ADDR_W-1:0] r;
    r = addr >> word_shift(code);
    return r[DPR_ROW_W-1:0];
  endfunction

  // logical bit of a physical column, -1 for an unused ninth bit
  function automatic int pos_of(input logic g9, input int c);
    if (g9) begin
      return c;
    end
    return (c % 9 == 8) ? -1 : (c / 9) * DPR_LANE8 + c % 9;
  endfunction

  function automatic int offset_of(
    input logic [3:0] code, input logic [DPR_ADDR_W-1:0] addr);
    logic [DPR_ADDR_W-1:0] low;
    low = addr & DPR_ADDR_W'((1 << word_shift(code)) - 1);
    return int'(low) * word_bits(code);
  endfunction

  // write mask in the low half, row data in the high half
  function automatic logic [71:0] place(
    input logic [3:0] code, input logic [DPR_ADDR_W-1:0] addr,
    input logic [3:0] be, input logic [35:0] din);
    logic [71:0] r;
    int          w;
    int          off;
    int          lane;
    int          pos;
    int          rel;
    r    = '0;
    w    = word_bits(code);
    off  = offset_of(code, addr);
    lane = is_g9(code) ? DPR_LANE9 : DPR_LANE8;
    for (int c = 0; c < DPR_DATA_W; c++) begin
      pos = pos_of(is_g9(code), c);
      rel = pos - off;
      if (pos >= 0 && rel >= 0 && rel < w) begin
        // lane gating; all nine bits of a lane follow its enable
        r[c]      = (w <= lane) || be[2'(rel / lane)];
        r[36 + c] = din[rel];
      end
    end
    return r;
  endfunction

  function automatic logic [35:0] extract(
    input logic [3:0] code, input logic [DPR_ADDR_W-1:0] addr,
    input logic [35:0] row);
    logic [35:0] d;
    int          w;
    int          off;
    int          pos;
    int          rel;
    d   = '0;
    w   = word_bits(code);
    off = offset_of(code, addr);
    for (int c = 0; c < DPR_DATA_W; c++) begin
      pos = pos_of(is_g9(code), c);
      rel = pos - off;
      if (pos >= 0 && rel >= 0 && rel < w) begin
        d[rel] = row[c];
      end
    end
    return d;
  endfunction

  // ****************************************************************
  // per-port views
  // ****************************************************************
  logic [1:0]            tick;
  logic [1:0]            we;
  logic [1:0]            oce;
  logic [1:0]            pipe_mode;
  logic [3:0]            width  [2];
  dpr_wmode_t            wmode  [2];
  logic [DPR_ADDR_W-1:0] addr   [2];
  logic [35:0]           din    [2];
  logic [3:0]            be     [2];
  logic [71:0]           placed [2];
  logic [35:0]           row_q  [2];

  assign tick      = {port_b_clock_i & port_b_ce_i,
                      port_a_clock_i & port_a_ce_i};
  assign we        = {port_b_write_enable_i, port_a_write_enable_i};
  assign oce       = {port_b_output_reg_enable_i,
                      port_a_output_reg_enable_i};
  assign pipe_mode = {port_b_pipeline_i, port_a_pipeline_i};
  assign width[0]  = port_a_width_i;
  assign width[1]  = port_b_width_i;
  assign wmode[0]  = port_a_write_mode_i;
  assign wmode[1]  = port_b_write_mode_i;
  assign addr[0]   = port_a_addr_i;
  assign addr[1]   = port_b_addr_i;
  assign din[0]    = port_a_data_i;
  assign din[1]    = port_b_data_i;
  assign be[0]     = port_a_byte_en_i;
  assign be[1]     = port_b_byte_en_i;
  assign placed[0] = place(width[0], addr[0], be[0], din[0]);
  assign placed[1] = place(width[1], addr[1], be[1], din[1]);

  // ****************************************************************
  // configuration check
  // ****************************************************************
  logic wide_a;
  logic wide_b;
  logic bad_code;
  logic illegal;

  assign wide_a   = port_a_width_i == DPR_W32 || port_a_width_i == DPR_W36;
  assign wide_b   = port_b_width_i == DPR_W32 || port_b_width_i == DPR_W36;
  assign bad_code = port_a_width_i > DPR_W36 || port_b_width_i > DPR_W36;

  // width pairing and clock mode legality
  always_comb begin
    case (port_mode_i)
      DPR_SINGLE: illegal = port_a_width_i > DPR_W36
                            || clock_mode_i != DPR_CLK_SINGLE;
      DPR_DUAL:   illegal = bad_code || wide_a || wide_b
                            || is_g9(port_a_width_i) != is_g9(port_b_width_i)
                            || clock_mode_i == DPR_CLK_SINGLE;
      DPR_SEMI:   illegal = bad_code || port_b_width_i == DPR_W36
                            || is_g9(port_a_width_i) != is_g9(port_b_width_i)
                            || clock_mode_i != DPR_CLK_RW;
      default:    illegal = 1'b1;
    endcase
  end

  // a bad setup blocks every access rather than corrupting the array
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cfg_error_o <= 1'b0;
    end else begin
      cfg_error_o <= illegal;
    end
  end

  // ****************************************************************
  // access qualification
  // ****************************************************************
  logic [1:0] wr_go;
  logic [1:0] rd_go;
  logic       indep;

  assign indep = clock_mode_i == DPR_CLK_INDEP;
  // each port acts only on its own clock edge
  assign wr_go[0] = !illegal && tick[0] && we[0];
  assign rd_go[0] = !illegal && tick[0] && !we[0]
                    && clock_mode_i != DPR_CLK_RW;
  assign wr_go[1] = !illegal && tick[1] && we[1] && indep;
  assign rd_go[1] = !illegal && tick[1] && port_mode_i != DPR_SINGLE
                    && !(we[1] && indep);

  // the ninth bit travels through the array untouched
  dpr_mem u_mem (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .en_i      (wr_go | rd_go),
    .we_i      (wr_go),
    .row_a_i   (row_of(width[0], addr[0])),
    .row_b_i   (row_of(width[1], addr[1])),
    .mask_a_i  (placed[0][35:0]),
    .mask_b_i  (placed[1][35:0]),
    .wdata_a_i (placed[0][71:36]),
    .wdata_b_i (placed[1][71:36]),
    .rdata_a_o (row_q[0]),
    .rdata_b_o (row_q[1])
  );

  // ****************************************************************
  // captured access, registered on the same edge as the array read
  // ****************************************************************
  logic [1:0]            s1_v;
  logic [1:0]            s1_we;
  logic [3:0]            s1_code [2];
  logic [DPR_ADDR_W-1:0] s1_addr [2];
  logic [71:0]           s1_put  [2];
  dpr_wmode_t            s1_wm   [2];

  // input side registered on the port edge
  always_ff @(posedge sys_clk_i) begin
    for (int p = 0; p < 2; p++) begin
      if (!rst_n_i) begin
        s1_v[p]    <= 1'b0;
        s1_we[p]   <= 1'b0;
        s1_code[p] <= DPR_W1;
        s1_addr[p] <= '0;
        s1_put[p]  <= '0;
        s1_wm[p]   <= DPR_WR_NORMAL;
      end else begin
        s1_v[p] <= wr_go[p] | rd_go[p];
        if (wr_go[p] | rd_go[p]) begin
          s1_we[p]   <= wr_go[p];
          s1_code[p] <= width[p];
          s1_addr[p] <= addr[p];
          s1_put[p]  <= placed[p];
          s1_wm[p]   <= wmode[p];
        end
      end
    end
  end

  // ****************************************************************
  // write-mode selection of the value shown
  // ****************************************************************
  logic [35:0] val [2];
  logic [1:0]  upd;

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      // normal write produces no update at all
      upd[p] = s1_v[p] && !(s1_we[p] && s1_wm[p] == DPR_WR_NORMAL);
      // write-through shows the word just written
      if (s1_we[p] && s1_wm[p] == DPR_WR_THRU) begin
        val[p] = extract(s1_code[p], s1_addr[p], s1_put[p][71:36]);
      end else begin
        // read-first array returns the old row on a write
        val[p] = extract(s1_code[p], s1_addr[p], row_q[p]);
      end
    end
  end

  // ****************************************************************
  // pipeline and output registers
  // ****************************************************************
  logic [35:0] pipe_q [2];
  logic [35:0] dout   [2];

  // pipeline stage loads on reads and on write-through or read-before-write writes, not normal
  always_ff @(posedge sys_clk_i) begin
    for (int p = 0; p < 2; p++) begin
      if (!rst_n_i) begin
        pipe_q[p] <= DPR_DOUT_RST;
      end else if (upd[p]) begin
        pipe_q[p] <= val[p];
      end
    end
  end

  // bypass takes the array value, pipeline waits on enable
  always_ff @(posedge sys_clk_i) begin
    for (int p = 0; p < 2; p++) begin
      if (!rst_n_i) begin
        dout[p] <= DPR_DOUT_RST;
      end else if (!pipe_mode[p]) begin
        if (upd[p]) begin
          dout[p] <= val[p];
        end
      end else if (oce[p] && tick[p]) begin
        dout[p] <= pipe_q[p];
      end
    end
  end

  assign port_a_data_o = dout[0];
  assign port_b_data_o = dout[1];

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_reset_zero: assert property (@(posedge sys_clk_i)
    !rst_n_i |=> port_a_data_o == '0 && port_b_data_o == '0)
    else $error("outputs not zero after reset");

  chk_cfg_pairing: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    (port_mode_i == DPR_DUAL && ((port_a_width_i == DPR_W9
     && port_b_width_i == DPR_W8) || (port_a_width_i == DPR_W8
     && port_b_width_i == DPR_W9))) |=> cfg_error_o)
    else $error("cross-group pairing accepted");

  chk_semi_wide: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    (port_mode_i == DPR_SEMI && port_b_width_i == DPR_W36)
    |-> !rd_go[1] && !wr_go[0])
    else $error("36-bit read side accepted");

  chk_semi_bwrite: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    port_mode_i == DPR_SEMI |-> !wr_go[1] && !(rd_go[0] && tick[0]))
    else $error("semi-dual port misuse");

  chk_lane_gate: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    (port_a_width_i == DPR_W36 && !port_a_byte_en_i[1])
    |-> placed[0][17:9] == 9'h000)
    else $error("disabled lane still written");

  chk_normal_hold: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    (wr_go[0] && port_a_write_mode_i == DPR_WR_NORMAL
     && !port_a_pipeline_i) ##1 !port_a_pipeline_i
    |=> $stable(port_a_data_o))
    else $error("normal write changed output");

  chk_write_thru: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    (wr_go[0] && port_a_write_mode_i == DPR_WR_THRU
     && port_a_width_i == DPR_W18 && !port_a_pipeline_i)
    ##1 !port_a_pipeline_i
    |=> port_a_data_o == {18'h0, $past(port_a_data_i[17:0], 2)})
    else $error("written word not shown");

  chk_rbw_old: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    (wr_go[0] && !wr_go[1] && port_a_width_i == DPR_W18
     && port_a_byte_en_i == 4'h3)
    ##1 (!wr_go[0] && !wr_go[1]) [*2]
    ##1 (wr_go[0] && port_a_write_mode_i == DPR_WR_RBW
         && port_a_width_i == DPR_W18 && !port_a_pipeline_i
         && port_a_addr_i == $past(port_a_addr_i, 3))
    ##1 !port_a_pipeline_i
    |=> port_a_data_o == {18'h0, $past(port_a_data_i[17:0], 5)})
    else $error("old contents not shown");

  chk_pipe_hold: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    (port_b_pipeline_i && !(port_b_output_reg_enable_i && tick[1]))
    |=> $stable(port_b_data_o))
    else $error("output register moved while disabled");

  chk_rw_clock: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    clock_mode_i == DPR_CLK_RW |-> !rd_go[0] && !wr_go[1]
    && (wr_go[0] -> tick[0]) && (rd_go[1] -> tick[1]))
    else $error("read/write clock split broken");

endmodule

/* testbench/dpr_user_port.sv */
// user-logic model that drives one memory port, one access per request
// assumes the bench raises go_i for exactly one cycle per access
`timescale 1ns/1ps
module dpr_user_port
  import dpr_pkg::*;
(
  input  wire logic                  sys_clk_i,
  input  wire logic                  go_i,
  input  wire logic                  we_i,
  input  wire logic [DPR_ADDR_W-1:0] addr_i,
  input  wire logic [DPR_DATA_W-1:0] data_i,
  input  wire logic [DPR_BE_W-1:0]   be_i,
  output logic                       pulse_o,
  output logic                       we_o,
  output logic      [DPR_ADDR_W-1:0] addr_o,
  output logic      [DPR_DATA_W-1:0] data_o,
  output logic      [DPR_BE_W-1:0]   be_o
);
  // ****************************************************************
  // access launch
  // ****************************************************************
  // quiet values at time zero
  initial begin
    pulse_o = 1'h0;
    we_o    = 1'h0;
    addr_o  = '0;
    data_o  = '0;
    be_o    = '0;
  end

  // enable per access
  // between accesses the fields flip, so stale values never look valid
  always @(posedge sys_clk_i) begin
    pulse_o <= go_i;
    we_o    <= go_i & we_i;
    addr_o  <= go_i ? addr_i : ~addr_o;
    data_o  <= go_i ? data_i : ~data_o;
    be_o    <= go_i ? be_i : ~be_o;
  end
endmodule

/* testbench/test_dual_port_block_ram.sv */
// self-checking bench for the dual-port block memory
// assumes one 200 MHz clock and a user-logic model on each port
`timescale 1ns/1ps
module test_dual_port_block_ram
  import dpr_pkg::*;
;
  typedef struct {int due; int port; logic [35:0] val;} dpr_note_t;

  // ****************************************************************
  // stimulus state
  // ****************************************************************
  logic        sys_clk = 1'h0;
  logic        rst_n   = 1'h0;
  dpr_pmode_t  pmode   = DPR_DUAL;
  dpr_cmode_t  cmode   = DPR_CLK_INDEP;
  logic [3:0]  wid_a   = DPR_W18;
  logic [3:0]  wid_b   = DPR_W9;
  dpr_wmode_t  wm_a    = DPR_WR_NORMAL;
  dpr_wmode_t  wm_b    = DPR_WR_NORMAL;
  logic        pipe_b  = 1'h0;
  logic        oce_b   = 1'h0;
  logic        go_a    = 1'h0;
  logic        go_b    = 1'h0;
  logic        we_r    = 1'h0;
  logic [13:0] ad_r    = 14'h0;
  logic [35:0] dt_r    = 36'h0;
  logic [3:0]  be_r    = 4'h0;
  logic        pa_clk, pa_we, pb_clk, pb_we, cfg_err;
  logic [13:0] pa_ad, pb_ad;
  logic [35:0] pa_dt, pb_dt, a_do, b_do;
  logic [3:0]  pa_be, pb_be;
  dpr_note_t   q[$];
  int          cyc        = 0;
  int          seed       = 32'h51c4;
  int          n_mismatch = 0;
  int          compares   = 0;

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) cyc <= cyc + 1;

  dpr_user_port u_a (.sys_clk_i(sys_clk), .go_i(go_a), .we_i(we_r),
    .addr_i(ad_r), .data_i(dt_r), .be_i(be_r), .pulse_o(pa_clk),
    .we_o(pa_we), .addr_o(pa_ad), .data_o(pa_dt), .be_o(pa_be));
  dpr_user_port u_b (.sys_clk_i(sys_clk), .go_i(go_b), .we_i(we_r),
    .addr_i(ad_r), .data_i(dt_r), .be_i(be_r), .pulse_o(pb_clk),
    .we_o(pb_we), .addr_o(pb_ad), .data_o(pb_dt), .be_o(pb_be));

  // port a keeps bypass; its output stage is left to port b's tests
  dpr_top DUT (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
    .port_mode_i(pmode), .clock_mode_i(cmode),
    .port_a_clock_i(pa_clk), .port_b_clock_i(pb_clk),
    .port_a_ce_i(1'h1), .port_b_ce_i(1'h1),
    .port_a_write_enable_i(pa_we), .port_b_write_enable_i(pb_we),
    .port_a_width_i(wid_a), .port_b_width_i(wid_b),
    .port_a_write_mode_i(wm_a), .port_b_write_mode_i(wm_b),
    .port_a_pipeline_i(1'h0), .port_b_pipeline_i(pipe_b),
    .port_a_output_reg_enable_i(1'h0),
    .port_b_output_reg_enable_i(oce_b),
    .port_a_addr_i(pa_ad), .port_b_addr_i(pb_ad),
    .port_a_data_i(pa_dt), .port_b_data_i(pb_dt),
    .port_a_byte_en_i(pa_be), .port_b_byte_en_i(pb_be),
    .port_a_data_o(a_do), .port_b_data_o(b_do), .cfg_error_o(cfg_err));

  // ****************************************************************
  // driver tasks; notes are due a set count of edges after launch, 5 by default in acc, 3 in cfg
  // ****************************************************************
  task automatic acc(input int p, input logic we, input logic [13:0] ad,
                     input logic [35:0] dt, input logic [3:0] be,
                     input int ep, input logic [35:0] ev,
                     input int dly = 5);
    @(posedge sys_clk);
    if (ep >= 0) q.push_back('{cyc + dly, ep, ev});
    if (p == 0) go_a <= 1'h1;
    else go_b <= 1'h1;
    we_r <= we;
    ad_r <= ad;
    dt_r <= dt;
    be_r <= be;
    @(posedge sys_clk);
    go_a <= 1'h0;
    go_b <= 1'h0;
  endtask

  task automatic cfg(input dpr_pmode_t pm, input dpr_cmode_t cm,
                     input logic [3:0] wa, input logic [3:0] wb,
                     input logic e);
    @(posedge sys_clk);
    pmode <= pm;
    cmode <= cm;
    wid_a <= wa;
    wid_b <= wb;
    q.push_back('{cyc + 3, 2, {35'h0, e}});
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic finish_test();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ****************************************************************
  // monitor: settled outputs against the oldest note, plus timeout
  // ****************************************************************
  always @(negedge sys_clk) begin
    logic [35:0] got;
    while (q.size() > 0 && q[0].due == cyc) begin
      got = (q[0].port == 0) ? a_do :
            (q[0].port == 1) ? b_do : {35'h0, cfg_err};
      compares++;
      if (got !== q[0].val) begin
        n_mismatch++;
        $display("MISMATCH t=%0t exp=%h got=%h", $time, q[0].val, got);
      end
      void'(q.pop_front());
    end
    if (cyc >= 3000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [35:0] d1, d2, d3, d4, d5, d6;
    d1 = 36'({$random(seed), $random(seed)}) | 36'h2_0100;
    d2 = ~d1;
    d3 = 36'({$random(seed), $random(seed)});
    d4 = 36'({$random(seed), $random(seed)});
    d5 = ~d4;
    d6 = 36'({$random(seed), $random(seed)});
    q.push_back('{1, 0, 36'h0});
    q.push_back('{1, 1, 36'h0});
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge sys_clk);
    // mixed widths: x18 writes on a, x9 reads on b, ninth bits set
    acc(0, 1, 0, d1, 4'h3, 0, 36'h0);
    acc(1, 0, 0, 0, 0, 1, {27'h0, d1[8:0]});
    acc(1, 0, 1, 0, 0, 1, {27'h0, d1[17:9]});
    // lane 0 only; lane 1 keeps all nine bits
    acc(0, 1, 0, d2, 4'h1, -1, 36'h0);
    acc(1, 0, 0, 0, 0, 1, {27'h0, d2[8:0]});
    acc(1, 0, 1, 0, 0, 1, {27'h0, d1[17:9]});
    // port b writes x9 words that port a then reads back as one x18 word
    acc(1, 1, 2, d3, 4'h0, 1, {27'h0, d1[17:9]});
    acc(1, 1, 3, d3 >> 9, 4'h0, -1, 36'h0);
    acc(0, 0, 1, 0, 0, 0, {18'h0, d3[17:0]});
    // the port edge of the last access comes one edge after return
    @(posedge sys_clk);
    wm_a <= DPR_WR_THRU;
    acc(0, 1, 2, d4, 4'h3, 0, {18'h0, d4[17:0]});
    @(posedge sys_clk);
    wm_a <= DPR_WR_RBW;
    acc(0, 1, 2, d5, 4'h3, 0, {18'h0, d4[17:0]});
    acc(1, 0, 4, 0, 0, 1, {27'h0, d5[8:0]});
    // pipeline on b: hold while enable low, then load stage contents
    // wait until the last bypass read has reached the output
    repeat (2) @(posedge sys_clk);
    pipe_b <= 1'h1;
    acc(1, 0, 0, 0, 0, -1, 36'h0);
    @(posedge sys_clk);
    acc(1, 0, 1, 0, 0, 1, {27'h0, d5[8:0]}, 3);
    @(posedge sys_clk);
    oce_b <= 1'h1;
    acc(1, 0, 5, 0, 0, 1, {27'h0, d1[17:9]}, 3);
    // the loading port edge must still see pipeline mode and enable
    repeat (2) @(posedge sys_clk);
    pipe_b <= 1'h0;
    oce_b <= 1'h0;
    // legality of width pairings and clock modes
    cfg(DPR_DUAL, DPR_CLK_INDEP, DPR_W36, DPR_W36, 1'h1);
    cfg(DPR_DUAL, DPR_CLK_RW, DPR_W8, DPR_W16, 1'h0);
    cfg(DPR_DUAL, DPR_CLK_INDEP, DPR_W8, DPR_W9, 1'h1);
    cfg(DPR_DUAL, DPR_CLK_SINGLE, DPR_W8, DPR_W8, 1'h1);
    cfg(DPR_SEMI, DPR_CLK_RW, DPR_W32, DPR_W36, 1'h1);
    cfg(DPR_SEMI, DPR_CLK_INDEP, DPR_W8, DPR_W8, 1'h1);
    cfg(DPR_SEMI, DPR_CLK_RW, DPR_W9, DPR_W32, 1'h1);
    cfg(DPR_SINGLE, DPR_CLK_SINGLE, DPR_W36, DPR_W1, 1'h0);
    cfg(DPR_SINGLE, DPR_CLK_RW, DPR_W8, DPR_W8, 1'h1);
    cfg(DPR_SEMI, DPR_CLK_RW, DPR_W36, DPR_W9, 1'h0);
    // semi-dual: a writes x36, b write refused, b reads x9
    acc(0, 1, 5, d6, 4'hF, -1, 36'h0);
    acc(1, 1, 20, ~d6, 4'hF, -1, 36'h0);
    acc(1, 0, 20, 0, 0, 1, {27'h0, d6[8:0]});
    acc(1, 0, 23, 0, 0, 1, {27'h0, d6[35:27]});
    repeat (10) @(posedge sys_clk);
    finish_test();
  end
endmodule
